//--- design/ddli_device.sv
// Contract
// - Mode high: two independent converter channels
// - Data straight binary, bit zero LSB
// - Strobe loads input latch, clock loads DAC
// - Refresh every edge dual, alternate interleaved
// - Update clock up to 125 MSPS; device sees edges only up to half the ref_clk rate
// - Host: clock before strobe, else 2 ns
// - Host: advised data change on falling
// - Mode low: pins reassigned for interleave
// - Shared strobe steers by select level
// - Host: select changes only both low
// - Sync reset blocks clock; next edge loads
// - Interleaved clock divided by two
// - Host: shared clock no later than strobe
// - Host: tie strobe/clock only at 5 V
// - Sleep input pulled down, stays enabled
`timescale 1ns/10ps
`default_nettype none
module ddli_device #(
    parameter int DATA_W = ddli_pkg::DATA_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    ddli_link_if.device link,
    output logic [DATA_W-1:0] dac1_code,
    output logic [DATA_W-1:0] dac2_code,
    output logic dac1_update,
    output logic dac2_update,
    output logic dac_enabled
);
    import ddli_pkg::*;

    // ==========================================
    // Pin roles
    // ==========================================
    logic interleaved;
    logic channel_steer_select;
    logic divider_sync_reset;

    // Interleaved mode reuses the port 2 pins as steer select and sync reset
    assign interleaved = (link.mode_dual == MODE_INTERLEAVED);
    assign channel_steer_select = link.port2_write_strobe;
    assign divider_sync_reset = link.port2_update_clock;

    // ==========================================
    // Edge detection of sampled strobes
    // ==========================================
    logic wr1_q;
    logic wr2_q;
    logic ck1_q;
    logic ck2_q;
    logic wr1_rise;
    logic wr2_rise;
    logic ck1_rise;
    logic ck2_rise;

    function automatic logic rise(input logic now, input logic prev);
        rise = now && !prev;
    endfunction

    assign wr1_rise = rise(link.port1_write_strobe, wr1_q);
    assign wr2_rise = rise(link.port2_write_strobe, wr2_q);
    assign ck1_rise = rise(link.port1_update_clock, ck1_q);
    assign ck2_rise = rise(link.port2_update_clock, ck2_q);

    // Pins sampled once per ref_clk: each level must last a full cycle,
    // so update rates above half the ref_clk rate are missed
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr1_q <= 1'b0;
            ck1_q <= 1'b0;
        end else if (clk_en) begin
            wr1_q <= link.port1_write_strobe;
            ck1_q <= link.port1_update_clock;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr2_q <= 1'b0;
            ck2_q <= 1'b0;
        end else if (clk_en) begin
            wr2_q <= link.port2_write_strobe;
            ck2_q <= link.port2_update_clock;
        end
    end

    // ==========================================
    // Channel input latches
    // ==========================================
    logic [DATA_W-1:0] in_latch1;
    logic [DATA_W-1:0] in_latch2;
    logic load_in1;
    logic load_in2;

    function automatic logic steer_hit(input logic select, input logic want);
        steer_hit = (select == want);
    endfunction

    assign load_in1 = interleaved ? (wr1_rise && steer_hit(channel_steer_select, STEER_CH1)) : wr1_rise;
    assign load_in2 = interleaved ? (wr1_rise && steer_hit(channel_steer_select, STEER_CH2)) : wr2_rise;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_latch1 <= DATA_W'(DATA_RESET);
        end else if (clk_en && load_in1) begin
            in_latch1 <= link.port1_data[DATA_W-1:0];
        end
    end

    // Interleaved words for channel 2 still arrive on the port 1 bus
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_latch2 <= DATA_W'(DATA_RESET);
        end else if (clk_en && load_in2) begin
            if (interleaved) begin
                in_latch2 <= link.port1_data[DATA_W-1:0];
            end else begin
                in_latch2 <= link.port2_data[DATA_W-1:0];
            end
        end
    end

    // ==========================================
    // Interleave divider and sync reset
    // ==========================================
    logic div_phase;

    // Cleared in dual mode, so a switch to interleaved starts on a loading edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_phase <= 1'b0;
        end else if (clk_en) begin
            if (!interleaved || divider_sync_reset) begin
                div_phase <= 1'b0;
            end else if (ck1_rise) begin
                div_phase <= !div_phase;
            end
        end
    end

    // ==========================================
    // DAC latch load decision
    // ==========================================
    logic iq_load;
    logic load_dac1;
    logic load_dac2;

    // Sync reset masks the shared clock; phase 0 marks the edge that loads
    assign iq_load = interleaved && !divider_sync_reset && ck1_rise && !div_phase;
    // Clock and strobe in one sample move the old content, as the clock leads
    assign load_dac1 = interleaved ? iq_load : ck1_rise;
    assign load_dac2 = interleaved ? iq_load : ck2_rise;

    // ==========================================
    // Channel 1 DAC latch
    // ==========================================
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac1_code <= DATA_W'(DATA_RESET);
        end else if (clk_en && load_dac1) begin
            dac1_code <= in_latch1;
        end
    end

    // One-cycle marker of each DAC latch load
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac1_update <= 1'b0;
        end else if (clk_en) begin
            dac1_update <= load_dac1;
        end
    end

    // ==========================================
    // Channel 2 DAC latch
    // ==========================================
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac2_code <= DATA_W'(DATA_RESET);
        end else if (clk_en && load_dac2) begin
            dac2_code <= in_latch2;
        end
    end

    // Interleaved mode pulses both markers on the same edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac2_update <= 1'b0;
        end else if (clk_en) begin
            dac2_update <= load_dac2;
        end
    end

    // ==========================================
    // Sleep control
    // ==========================================
    // Missing sleep input reads low via pull-down, so device stays on
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_enabled <= 1'b1;
        end else if (clk_en) begin
            dac_enabled <= (link.sleep_req !== 1'b1);
        end
    end
endmodule // ddli_device
`default_nettype wire

//--- design/ddli_host.sv
`timescale 1ns/10ps
`default_nettype none
module ddli_host #(
    parameter int DATA_W = ddli_pkg::DATA_W,
    parameter int BUF_DEPTH = ddli_pkg::BUF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    ddli_link_if.host link,
    input wire logic mode_dual,
    input wire logic sleep,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [DATA_W-1:0] word_data,
    input wire logic word_chan1,
    output logic busy
);
    import ddli_pkg::*;

    // ==========================================
    // Input buffer
    // ==========================================
    logic buf_valid;
    logic buf_ready;
    logic [DATA_W:0] buf_data;
    ddli_host_state_t state;
    logic word_ch1;
    logic sync_due;

    ddli_skid_buf #(.WIDTH(DATA_W + 1), .DEPTH(BUF_DEPTH)) u_buf (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data({word_chan1, word_data}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // A switch to interleaved first pulses the sync reset; no word leaves in that cycle
    assign sync_due = (mode_dual == MODE_INTERLEAVED) && (link.mode_dual == MODE_DUAL);
    assign buf_ready = (state == DDLI_IDLE) && !sync_due;

    // ==========================================
    // Sequencer: data, clock, strobe, all low
    // ==========================================
    // Clock rises one cycle before strobe, beyond the 2 ns gap; select moves only when both low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= DDLI_IDLE;
            word_ch1 <= 1'b0;
            link.mode_dual <= MODE_DUAL;
            link.sleep_req <= 1'b0;
            link.port1_data <= '0;
            link.port2_data <= '0;
            link.port1_write_strobe <= 1'b0;
            link.port2_write_strobe <= 1'b0;
            link.port1_update_clock <= 1'b0;
            link.port2_update_clock <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            link.sleep_req <= sleep;
            case (state)
                DDLI_IDLE: begin
                    link.port1_write_strobe <= 1'b0;
                    link.port1_update_clock <= 1'b0;
                    link.port2_update_clock <= sync_due;
                    link.mode_dual <= mode_dual;
                    busy <= buf_valid;
                    if (mode_dual == MODE_DUAL) begin
                        link.port2_write_strobe <= 1'b0;
                    end
                    if (buf_valid && !sync_due) begin
                        if (mode_dual == MODE_DUAL) begin
                            if (buf_data[DATA_W]) begin
                                link.port1_data <= buf_data[DATA_W-1:0];
                            end else begin
                                link.port2_data <= buf_data[DATA_W-1:0];
                            end
                        end else begin
                            link.port1_data <= buf_data[DATA_W-1:0];
                            link.port2_write_strobe <= buf_data[DATA_W];
                        end
                        word_ch1 <= buf_data[DATA_W];
                        state <= DDLI_UPDATE;
                    end
                end
                DDLI_UPDATE: begin
                    if (link.mode_dual == MODE_DUAL) begin
                        link.port1_update_clock <= word_ch1;
                        link.port2_update_clock <= !word_ch1;
                    end else begin
                        link.port1_update_clock <= 1'b1;
                    end
                    state <= DDLI_STROBE;
                end
                DDLI_STROBE: begin
                    if (link.mode_dual == MODE_DUAL) begin
                        link.port1_write_strobe <= word_ch1;
                        link.port2_write_strobe <= !word_ch1;
                    end else begin
                        link.port1_write_strobe <= 1'b1;
                    end
                    state <= DDLI_DATA;
                end
                DDLI_DATA: begin
                    link.port1_write_strobe <= 1'b0;
                    link.port1_update_clock <= 1'b0;
                    link.port2_update_clock <= 1'b0;
                    if (link.mode_dual == MODE_DUAL) begin
                        link.port2_write_strobe <= 1'b0;
                    end
                    state <= DDLI_IDLE;
                end
                default: state <= DDLI_IDLE;
            endcase
        end
    end
endmodule // ddli_host
`default_nettype wire

//--- design/ddli_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ddli_link_if;
    import ddli_pkg::*;
    logic mode_dual;
    logic sleep_req;
    ddli_word_t port1_data;
    ddli_word_t port2_data;
    logic port1_write_strobe;
    logic port2_write_strobe;
    logic port1_update_clock;
    logic port2_update_clock;
    modport device (
        input mode_dual, sleep_req, port1_data, port2_data,
        input port1_write_strobe, port2_write_strobe, port1_update_clock, port2_update_clock
    );
    modport host (
        output mode_dual, sleep_req, port1_data, port2_data,
        output port1_write_strobe, port2_write_strobe, port1_update_clock, port2_update_clock
    );
endinterface
`default_nettype wire

//--- design/ddli_pkg.sv
package ddli_pkg;
    // Data word width of the widest variant
    localparam int DATA_W = 14;
    localparam logic MODE_DUAL = 1'b1;
    localparam logic MODE_INTERLEAVED = 1'b0;
    localparam logic STEER_CH1 = 1'b1;
    localparam logic STEER_CH2 = 1'b0;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MAX_UPDATE_MSPS = 125;
    localparam int STROBE_TO_CLOCK_NS = 2;
    localparam int STROBE_TO_CLOCK_CYC = (STROBE_TO_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [13:0] DATA_RESET = 14'h0000;
    localparam int BUF_DEPTH = 2;
    typedef logic [DATA_W-1:0] ddli_word_t;
    typedef enum logic [1:0] {DDLI_IDLE, DDLI_DATA, DDLI_STROBE, DDLI_UPDATE} ddli_host_state_t;
endpackage

//--- design/ddli_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module ddli_skid_buf #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ddli_skid_buf
`default_nettype wire

//--- test/ddli_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ddli_sva (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic mode_dual,
    input wire logic sleep_req,
    input wire ddli_pkg::ddli_word_t port1_data,
    input wire ddli_pkg::ddli_word_t port2_data,
    input wire logic port1_write_strobe,
    input wire logic port2_write_strobe,
    input wire logic port1_update_clock,
    input wire logic port2_update_clock,
    input wire ddli_pkg::ddli_word_t dac1_code,
    input wire ddli_pkg::ddli_word_t dac2_code,
    input wire logic dac1_update,
    input wire logic dac2_update,
    input wire logic dac_enabled
);
    import ddli_pkg::*;
    ddli_word_t lat1, lat2;
    logic pw1, pw2, pc1, iq_ph;
    logic wr1_rise, wr2_rise;
    assign wr1_rise = port1_write_strobe && !pw1;
    assign wr2_rise = port2_write_strobe && !pw2;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // Reference latches and divider phase
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) {pw1, pw2, pc1} <= 3'h0;
        else {pw1, pw2, pc1} <= {port1_write_strobe, port2_write_strobe, port1_update_clock};
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) lat1 <= '0;
        else if (wr1_rise && (mode_dual || port2_write_strobe)) lat1 <= port1_data;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) lat2 <= '0;
        else if (mode_dual && wr2_rise) lat2 <= port2_data;
        else if (!mode_dual && wr1_rise && !port2_write_strobe) lat2 <= port1_data;
    end
    // Phase 0 means the next shared clock rise loads both channels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) iq_ph <= 1'b0;
        else if (mode_dual || port2_update_clock) iq_ph <= 1'b0;
        else if (!mode_dual && port1_update_clock && !pc1) iq_ph <= ~iq_ph;
    end
    // ==========
    // Properties
    sequence s_iq_rise;
        !mode_dual && !port2_update_clock && $rose(port1_update_clock);
    endsequence
    sequence s_iq_load;
        s_iq_rise ##1 dac1_update;
    endsequence
    property p_dual_upd1;
        mode_dual && $rose(port1_update_clock) |=> dac1_update && dac1_code == $past(lat1);
    endproperty
    a_dual_upd1: assert property (p_dual_upd1) else $error("ch1 load wrong");
    property p_dual_upd2;
        mode_dual && $rose(port2_update_clock) |=> dac2_update && dac2_code == $past(lat2);
    endproperty
    a_dual_upd2: assert property (p_dual_upd2) else $error("ch2 load wrong");
    property p_dual_quiet;
        mode_dual && !$rose(port1_update_clock) |=> !dac1_update;
    endproperty
    a_dual_quiet: assert property (p_dual_quiet) else $error("ch1 spurious load");
    property p_iq_upd;
        s_iq_rise |=> dac1_update == !$past(iq_ph);
    endproperty
    a_iq_upd: assert property (p_iq_upd) else $error("divider phase wrong");
    property p_iq_data;
        s_iq_load |-> dac1_code == $past(lat1) && dac2_code == $past(lat2);
    endproperty
    a_iq_data: assert property (p_iq_data) else $error("steered data wrong");
    property p_iq_pair;
        !mode_dual |-> dac1_update == dac2_update;
    endproperty
    a_iq_pair: assert property (p_iq_pair) else $error("channels not together");
    property p_sync_block;
        !mode_dual && port2_update_clock |=> !dac1_update;
    endproperty
    a_sync_block: assert property (p_sync_block) else $error("load during sync");
    property p_hold;
        !dac1_update |-> $stable(dac1_code);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved without load");
    property p_sleep;
        dac_enabled == !$past(sleep_req);
    endproperty
    a_sleep: assert property (p_sleep) else $error("enable wrong");
    property p_clk_first1;
        $rose(port1_write_strobe) |-> $past(port1_update_clock);
    endproperty
    a_clk_first1: assert property (p_clk_first1) else $error("strobe before clock");
    property p_clk_first2;
        mode_dual && $rose(port2_write_strobe) |-> $past(port2_update_clock);
    endproperty
    a_clk_first2: assert property (p_clk_first2) else $error("strobe2 before clock2");
    property p_sel_quiet;
        !mode_dual && $changed(port2_write_strobe) |-> !port1_write_strobe && !port1_update_clock;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("select moved while high");
    property p_iq_apart;
        !mode_dual && $rose(port1_write_strobe) |-> !$rose(port1_update_clock);
    endproperty
    a_iq_apart: assert property (p_iq_apart) else $error("shared strobe tied to clock");
    property p_data_low;
        $changed(port1_data) |-> !port1_update_clock;
    endproperty
    a_data_low: assert property (p_data_low) else $error("data moved while clock high");
endmodule // ddli_sva
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import ddli_pkg::*;
    logic ref_clk = 0, rst_b = 0, clk_en = 1, mode_dual = 1, sleep = 0;
    logic word_valid = 0, word_chan1 = 0, word_ready, busy, saw_stall, pw1 = 0;
    ddli_word_t word_data = '0, dac1_code, dac2_code;
    logic dac1_update, dac2_update, dac_enabled;
    int n_errors = 0, samples_checked = 0, n_up1 = 0;
    logic [14:0] wr_q[$];
    ddli_link_if ddli_link_if_inst ();
    ddli_host ddli_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .link(ddli_link_if_inst.host),
        .mode_dual(mode_dual), .sleep(sleep), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .word_chan1(word_chan1), .busy(busy));
    ddli_device ddli_device_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .link(ddli_link_if_inst.device), .dac1_code(dac1_code), .dac2_code(dac2_code),
        .dac1_update(dac1_update), .dac2_update(dac2_update), .dac_enabled(dac_enabled));
    ddli_sva ddli_sva_inst (.ref_clk(ref_clk), .rst_b(rst_b), .mode_dual(ddli_link_if_inst.mode_dual),
        .sleep_req(ddli_link_if_inst.sleep_req), .port1_data(ddli_link_if_inst.port1_data),
        .port2_data(ddli_link_if_inst.port2_data), .port1_write_strobe(ddli_link_if_inst.port1_write_strobe),
        .port2_write_strobe(ddli_link_if_inst.port2_write_strobe),
        .port1_update_clock(ddli_link_if_inst.port1_update_clock),
        .port2_update_clock(ddli_link_if_inst.port2_update_clock), .dac1_code(dac1_code),
        .dac2_code(dac2_code), .dac1_update(dac1_update), .dac2_update(dac2_update), .dac_enabled(dac_enabled));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // ==========
    // Link monitor: steer level and word at each shared strobe rise
    always @(posedge ref_clk) begin
        if (dac1_update === 1'b1) n_up1++;
        if (ddli_link_if_inst.port1_write_strobe === 1'b1 && pw1 === 1'b0)
            wr_q.push_back({ddli_link_if_inst.port2_write_strobe, ddli_link_if_inst.port1_data});
        pw1 <= ddli_link_if_inst.port1_write_strobe;
    end
    // ==========
    // Tasks
    task conclude;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task do_reset;
        rst_b = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
    endtask
    // Holds valid across back-to-back words; caller drops it via drain
    task send(input ddli_word_t d, input logic c);
        int i;
        word_valid = 1'b1;
        word_data = d;
        word_chan1 = c;
        for (i = 0; i < 50; i++) begin
            if (word_ready === 1'b1) break;
            saw_stall = 1'b1;
            @(negedge ref_clk);
        end
        if (i == 50) begin
            n_errors++;
            conclude();
        end
        @(negedge ref_clk);
    endtask
    task drain;
        int i, quiet;
        word_valid = 1'b0;
        quiet = 0;
        for (i = 0; i < 200 && quiet < 8; i++) begin
            @(negedge ref_clk);
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 8) begin
            n_errors++;
            conclude();
        end
    endtask
    // Clock enable low must freeze the sleep path as well
    task t_sleep;
        clk_en = 1'b0;
        sleep = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(ddli_link_if_inst.sleep_req, 1'b0)
        `CHK(dac_enabled, 1'b1)
        clk_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(ddli_link_if_inst.sleep_req, 1'b1)
        `CHK(dac_enabled, 1'b0)
        sleep = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK(dac_enabled, 1'b1)
    endtask
    // Clock leads strobe, so each channel shows its previous word
    task t_dual;
        n_up1 = 0;
        saw_stall = 1'b0;
        wr_q.delete();
        send(14'h3fff, 1'b1);
        send(14'h0001, 1'b1);
        send(14'h2aaa, 1'b0);
        send(14'h1555, 1'b0);
        drain();
        `CHK(dac1_code, 14'h3fff)
        `CHK(dac2_code, 14'h2aaa)
        `CHK(n_up1, 2)
        `CHK(wr_q[0][13:0], 14'h3fff)
        `CHK(saw_stall, 1'b1)
    endtask
    task t_iq;
        mode_dual = 1'b0;
        do_reset();
        `CHK(dac1_code, 14'h0000)
        n_up1 = 0;
        wr_q.delete();
        send(14'h2001, 1'b1);
        send(14'h0c03, 1'b0);
        send(14'h1ff0, 1'b1);
        send(14'h0abc, 1'b0);
        drain();
        `CHK(dac1_code, 14'h2001)
        `CHK(dac2_code, 14'h0c03)
        `CHK(n_up1, 2)
        `CHK(wr_q[0], {1'b1, 14'h2001})
        `CHK(wr_q[1], {1'b0, 14'h0c03})
    endtask
    initial begin
        do_reset();
        t_sleep();
        t_dual();
        t_iq();
        conclude();
    end
endmodule // tb
`default_nettype wire
